// ===== src/scm_pkg.sv
// constants and types shared by the clock mode select block
package scm_pkg;

    // register offsets
    localparam logic [7:0] OFS_OP_MODE    = 8'h03;
    localparam logic [7:0] OFS_LEG_FORMAT = 8'h04;
    localparam logic [7:0] OFS_RATE_SEL   = 8'h05;
    localparam logic [7:0] OFS_CLK_MUL    = 8'h06;
    localparam logic [7:0] OFS_CLK_DIVN   = 8'h07;
    localparam logic [7:0] OFS_LEG_CFG    = 8'h10;
    localparam logic [7:0] OFS_LEG_DT     = 8'h11;

    // field positions
    localparam int OVERRIDE_BIT  = 4;
    localparam int RATE_SEL_BIT  = 3;
    localparam int MATCH_EN_BIT  = 6;
    localparam int CFG_LONG_BIT  = 0;
    localparam int CFG_YUV_BIT   = 1;

    // operating mode codes
    localparam logic [2:0] MODE_SYNC     = 3'h0;
    localparam logic [2:0] MODE_EXT      = 3'h2;
    localparam logic [2:0] MODE_INTERNAL = 3'h3;
    localparam logic [2:0] MODE_LEGACY   = 3'h5;

    // legacy format codes
    localparam logic [1:0] FMT_NONE    = 2'h0;
    localparam logic [1:0] FMT_RAW10   = 2'h1;
    localparam logic [1:0] FMT_RAW12HF = 2'h2;
    localparam logic [1:0] FMT_RAW12LF = 2'h3;

    // packet data types
    localparam logic [5:0] DT_RAW10   = 6'h2b;
    localparam logic [5:0] DT_RAW12   = 6'h2c;
    localparam logic [5:0] DT_LONG_LO = 6'h10;
    localparam logic [5:0] DT_YUV_LO  = 6'h18;
    localparam logic [5:0] DT_YUV_HI  = 6'h1f;

    // control bus target addresses
    localparam logic [6:0] ADDR_LOW  = 7'h18;
    localparam logic [6:0] ADDR_HIGH = 7'h19;

    // values after reset
    localparam logic [2:0] RST_PREDIV = 3'h2;
    localparam logic [4:0] RST_MUL    = 5'h01;
    localparam logic [7:0] RST_DIVN   = 8'h01;
    localparam logic [7:0] RST_BYTE   = 8'h00;

    // forward channel reference source
    typedef enum logic [1:0] {
        REF_RECOVERED,
        REF_EXTERNAL,
        REF_INTERNAL,
        REF_NONE
    } scm_ref_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_A,
        ST_WRITE,
        ST_ACK_W,
        ST_READ,
        ST_ACK_R
    } scm_i2c_state_type;

endpackage

// ===== src/scm_i2c_target.sv
// serial control bus target giving byte access to the register file
`timescale 1ns/1ps
`default_nettype none
module scm_i2c_target
    import scm_pkg::*;
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    // bus pins
    input  wire logic [6:0] dev_addr_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe_o,
    // register side
    output logic            wr_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    input  wire logic [7:0] rdata_i
);
    scm_i2c_state_type st_q;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt_q;
    logic [7:0] sr_q;
    logic [7:0] tx_q;
    logic       rw_q;
    logic       first_q;
    logic       rise;
    logic       fall;
    logic       start_c;
    logic       stop_c;

    // previous pin levels for edge and condition detection
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign rise    = scl_i & ~scl_q;
    assign fall    = ~scl_i & scl_q;
    assign start_c = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c  = scl_i & scl_q & ~sda_q & sda_i;

    // protocol sequencer, pointer auto-increments after each written or acknowledged read data byte
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 4'h0;
            sr_q    <= 8'h00;
            tx_q    <= 8'hff;
            rw_q    <= 1'b0;
            first_q <= 1'b0;
            wr_o    <= 1'b0;
            addr_o  <= 8'h00;
            wdata_o <= 8'h00;
        end else begin
            wr_o <= 1'b0;
            if (wr_o) begin
                addr_o <= addr_o + 8'h01;
            end
            if (start_c) begin
                st_q    <= ST_ADDR;
                cnt_q   <= 4'h0;
                first_q <= 1'b1;
            end else if (stop_c) begin
                st_q <= ST_IDLE;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        cnt_q <= 4'h0;
                    end
                    ST_ADDR, ST_WRITE: begin
                        if (rise) begin
                            sr_q  <= {sr_q[6:0], sda_i};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (fall && cnt_q == 4'h8) begin
                            if (st_q == ST_ADDR) begin
                                rw_q <= sr_q[0];
                                st_q <= (sr_q[7:1] == dev_addr_i) ? ST_ACK_A : ST_IDLE;
                            end else begin
                                st_q <= ST_ACK_W;
                                if (first_q) begin
                                    addr_o  <= sr_q;
                                    first_q <= 1'b0;
                                end else begin
                                    wr_o    <= 1'b1;
                                    wdata_o <= sr_q;
                                end
                            end
                        end
                    end
                    ST_ACK_A: begin
                        if (fall) begin
                            cnt_q <= 4'h0;
                            tx_q  <= rdata_i;
                            st_q  <= rw_q ? ST_READ : ST_WRITE;
                        end
                    end
                    ST_ACK_W: begin
                        if (fall) begin
                            cnt_q <= 4'h0;
                            st_q  <= ST_WRITE;
                        end
                    end
                    ST_READ: begin
                        if (fall) begin
                            if (cnt_q == 4'h7) begin
                                st_q <= ST_ACK_R;
                            end else begin
                                tx_q  <= {tx_q[6:0], 1'b1};
                                cnt_q <= cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_ACK_R: begin
                        if (rise) begin
                            if (sda_i) begin
                                st_q <= ST_IDLE;
                            end else begin
                                addr_o <= addr_o + 8'h01;
                            end
                        end else if (fall) begin
                            cnt_q <= 4'h0;
                            tx_q  <= rdata_i;
                            st_q  <= ST_READ;
                        end
                    end
                    default: begin
                        st_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // open drain: enable pulls the line low
    assign sda_oe_o = (st_q == ST_ACK_A) | (st_q == ST_ACK_W) | ((st_q == ST_READ) & ~tx_q[7]);

    wr_single_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_o |=> !wr_o && addr_o == $past(addr_o) + 8'h01)
        else $error("register write strobe not a single pulse");

endmodule
`default_nettype wire

// ===== src/scm_clock_mode_select.sv
// clock mode selection, sensor clock generator and legacy video registers
//
// Behaviour
// - internal mode takes the forward reference from the always-on oscillator.
// - sensor clock output held inactive in internal mode.
// - mode field always shows current mode; read only unless override bit set or set by the same write.
// - override bit set makes mode writable; code 5 selects legacy video.
// - mode strap captured when the power enable pin rises.
// - codes 0 recovered, 2 external, 3 internal, 5 legacy with external clock.
// - format override register forces legacy mode to RAW10 or RAW12.
// - low frequency RAW12 legacy format refused; RAW10 and RAW12 HF accepted.
// - legacy config register sets long packet, YUV and data type handling.
// - with match enable, programmed data type passes in either legacy format.
// - sensor clock equals rate times M over twice predivider times N.
// - sensor clock made by a digital accumulator; low jitter when N/M integral.
// - sensor clock provided in synchronous and external clock modes.
// - address strap chooses one of two seven-bit control bus addresses.
// - registers reached over an I2C-compatible serial control bus.
// - synchronous mode uses the recovered back channel clock as reference.
`timescale 1ns/1ps
`default_nettype none
module scm_clock_mode_select
    import scm_pkg::*;
(
    // clock and reset, reset release is the power enable pin rising
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    // straps
    input  wire logic [2:0] mode_strap_i,
    input  wire logic       address_select_strap_i,
    // serial control bus
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // clocking controls
    output scm_ref_type     ref_source_o,
    output logic            internal_rate_select_o,
    output logic            sensor_clock_enable_o,
    output logic            sensor_clock_o,
    output logic [6:0]      target_address_o,
    // legacy video path
    output logic            legacy_mode_o,
    output logic [1:0]      legacy_format_o,
    output logic [7:0]      legacy_port_config_o,
    input  wire logic       pkt_valid_i,
    input  wire logic [5:0] pkt_dt_i,
    output logic            pkt_pass_o
);
    logic       captured_q;
    logic [2:0] mode_q;
    logic       override_q;
    logic [1:0] fmt_q;
    logic       rate_sel_q;
    logic [2:0] prediv_q;
    logic [4:0] mul_q;
    logic [7:0] divn_q;
    logic [7:0] cfg_q;
    logic [7:0] dt_q;
    logic       addr_sel_q;
    logic       wr;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] pre_cnt_q;
    logic [4:0] pre_lim;
    logic       tick;
    logic [8:0] acc_q;
    logic [8:0] acc_sum;
    logic       clk_q;
    logic       pass_q;
    logic       dt_hit;
    logic       mode_wr_ok;

    // control bus target
    scm_i2c_target u_bus (
        .clock_i    (clock_i),
        .reset_n_i  (reset_n_i),
        .dev_addr_i (target_address_o),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_oe_o   (sda_oe_o),
        .wr_o       (wr),
        .addr_o     (waddr),
        .wdata_o    (wdata),
        .rdata_i    (rdata)
    );

    assign sda_o = 1'b0; // open drain only ever pulls low

    // straps are caught at the first edge after reset release
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            captured_q <= 1'b0;
            addr_sel_q <= 1'b0;
        end else if (!captured_q) begin
            captured_q <= 1'b1;
            addr_sel_q <= address_select_strap_i;
        end
    end

    assign target_address_o = addr_sel_q ? ADDR_HIGH : ADDR_LOW;

    // a write may set the override bit and the mode in one access
    assign mode_wr_ok = override_q | wdata[OVERRIDE_BIT];

    // operating mode field and its override bit
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q     <= MODE_SYNC;
            override_q <= 1'b0;
        end else if (!captured_q) begin
            mode_q <= mode_strap_i;
        end else if (wr && waddr == OFS_OP_MODE) begin
            override_q <= wdata[OVERRIDE_BIT];
            if (mode_wr_ok) begin
                mode_q <= wdata[2:0];
            end
        end
    end

    // legacy format override, low frequency RAW12 writes are dropped
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fmt_q <= FMT_NONE;
        end else if (wr && waddr == OFS_LEG_FORMAT && wdata[1:0] != FMT_RAW12LF) begin
            fmt_q <= wdata[1:0];
        end
    end

    // clocking and legacy configuration registers
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rate_sel_q <= 1'b0;
            prediv_q   <= RST_PREDIV;
            mul_q      <= RST_MUL;
            divn_q     <= RST_DIVN;
            cfg_q      <= RST_BYTE;
            dt_q       <= RST_BYTE;
        end else if (wr) begin
            case (waddr)
                OFS_RATE_SEL: rate_sel_q <= wdata[RATE_SEL_BIT];
                OFS_CLK_MUL: begin
                    prediv_q <= wdata[7:5];
                    mul_q    <= wdata[4:0];
                end
                OFS_CLK_DIVN: divn_q <= wdata;
                OFS_LEG_CFG: cfg_q <= wdata;
                OFS_LEG_DT: dt_q <= {1'b0, wdata[6:0]};
                default: ;
            endcase
        end
    end

    // register read mux, unmapped offsets read zero
    always_comb begin
        case (waddr)
            OFS_OP_MODE:    rdata = {3'h0, override_q, 1'b0, mode_q};
            OFS_LEG_FORMAT: rdata = {6'h00, fmt_q};
            OFS_RATE_SEL:   rdata = {4'h0, rate_sel_q, 3'h0};
            OFS_CLK_MUL:    rdata = {prediv_q, mul_q};
            OFS_CLK_DIVN:   rdata = divn_q;
            OFS_LEG_CFG:    rdata = cfg_q;
            OFS_LEG_DT:     rdata = dt_q;
            default:        rdata = 8'h00;
        endcase
    end

    // reference source decode
    always_comb begin
        case (mode_q)
            MODE_SYNC:     ref_source_o = REF_RECOVERED;
            MODE_EXT:      ref_source_o = REF_EXTERNAL;
            MODE_INTERNAL: ref_source_o = REF_INTERNAL;
            MODE_LEGACY:   ref_source_o = REF_EXTERNAL;
            default:       ref_source_o = REF_NONE;
        endcase
    end

    assign internal_rate_select_o = rate_sel_q;
    assign legacy_mode_o          = (mode_q == MODE_LEGACY);
    assign legacy_format_o        = fmt_q;
    assign legacy_port_config_o   = cfg_q;

    // sensor clock only in modes that have an outside reference
    assign sensor_clock_enable_o = (mode_q == MODE_SYNC) | (mode_q == MODE_EXT)
                                 | (mode_q == MODE_LEGACY);

    // predivider: code k divides by two to the k, capped at 16
    assign pre_lim = (prediv_q > 3'h4) ? 5'h0f : 5'((5'h01 << prediv_q) - 5'h01);

    // predivider enable pulse
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_cnt_q <= 5'h00;
        end else if (!sensor_clock_enable_o || pre_cnt_q >= pre_lim) begin
            pre_cnt_q <= 5'h00;
        end else begin
            pre_cnt_q <= pre_cnt_q + 5'h01;
        end
    end

    assign tick    = sensor_clock_enable_o && pre_cnt_q >= pre_lim;
    assign acc_sum = acc_q + {4'h0, mul_q};

    // fractional accumulator, one half period per overflow past N
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_q <= 9'h000;
            clk_q <= 1'b0;
        end else if (!sensor_clock_enable_o) begin
            acc_q <= 9'h000;
            clk_q <= 1'b0;
        end else if (tick && divn_q != 8'h00) begin
            if (acc_sum >= {1'b0, divn_q}) begin
                acc_q <= acc_sum - {1'b0, divn_q};
                clk_q <= ~clk_q;
            end else begin
                acc_q <= acc_sum;
            end
        end
    end

    assign sensor_clock_o = clk_q;

    // legacy packet filter
    always_comb begin
        dt_hit = 1'b0;
        if (dt_q[MATCH_EN_BIT] && pkt_dt_i == dt_q[5:0]) begin
            dt_hit = 1'b1;
        end
        if (fmt_q == FMT_RAW10 && pkt_dt_i == DT_RAW10) begin
            dt_hit = 1'b1;
        end
        if (fmt_q == FMT_RAW12HF && pkt_dt_i == DT_RAW12) begin
            dt_hit = 1'b1;
        end
        if (cfg_q[CFG_LONG_BIT] && pkt_dt_i >= DT_LONG_LO) begin
            dt_hit = 1'b1;
        end
        if (cfg_q[CFG_YUV_BIT] && pkt_dt_i >= DT_YUV_LO && pkt_dt_i <= DT_YUV_HI) begin
            dt_hit = 1'b1;
        end
    end

    // pass decision registered one cycle after the packet header
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pass_q <= 1'b0;
        end else begin
            pass_q <= pkt_valid_i & legacy_mode_o & dt_hit;
        end
    end

    assign pkt_pass_o = pass_q;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    // checks
    internal_ref_a: assert property (mode_q == MODE_INTERNAL |-> ref_source_o == REF_INTERNAL)
        else $error("internal mode not using oscillator");

    clkout_off_a: assert property ((mode_q == MODE_INTERNAL) [*2] |-> !sensor_clock_o)
        else $error("sensor clock active in internal mode");

    mode_locked_a: assert property (captured_q && wr && waddr == OFS_OP_MODE && !override_q
        && !wdata[OVERRIDE_BIT] |=> mode_q == $past(mode_q))
        else $error("mode changed without override");

    mode_write_a: assert property (captured_q && wr && waddr == OFS_OP_MODE && wdata[OVERRIDE_BIT]
        |=> mode_q == $past(wdata[2:0]) && override_q)
        else $error("override write did not set mode");

    strap_capture_a: assert property ($rose(captured_q) |-> mode_q == $past(mode_strap_i))
        else $error("mode strap not captured");

    sync_ref_a: assert property (mode_q == MODE_SYNC |-> ref_source_o == REF_RECOVERED
        && sensor_clock_enable_o)
        else $error("synchronous mode reference wrong");

    no_low_raw12_a: assert property (legacy_format_o != FMT_RAW12LF)
        else $error("low frequency RAW12 accepted");

    dt_pass_a: assert property (pkt_valid_i && legacy_mode_o && dt_q[MATCH_EN_BIT]
        && pkt_dt_i == dt_q[5:0] |=> pkt_pass_o)
        else $error("matching data type not passed");

    addr_strap_a: assert property ($rose(captured_q) |-> target_address_o
        == ($past(address_select_strap_i) ? ADDR_HIGH : ADDR_LOW))
        else $error("control bus address not from strap");

    clk_toggle_a: assert property (tick && divn_q == 8'h01 && mul_q == 5'h01 && $stable(divn_q)
        |=> sensor_clock_o != $past(sensor_clock_o))
        else $error("sensor clock failed to toggle at unit ratio");

    // scenarios
    override_c: cover property (wr && waddr == OFS_OP_MODE && wdata == 8'h15);
    legacy_pass_c: cover property (pkt_pass_o);
    clk_run_c: cover property ($rose(sensor_clock_o));
    internal_c: cover property (mode_q == MODE_INTERNAL && rate_sel_q);

endmodule
`default_nettype wire

// ===== tb/scm_host_model.sv
// serial control bus controller model driving the block's register bus
`timescale 1ns/1ps
`default_nettype none
module scm_host_model (
    // clock
    input  wire logic clock_i,
    // bus pins
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    // bus idles released
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // hold both lines four cycles so every phase stays over two cycles
    task automatic ph(input logic c, input logic d);
        scl_o = c;
        sda_oe_o = !d;
        repeat (4) @(negedge clock_i);
    endtask
    // start or repeated start, data falls while clock is high
    task automatic start();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
        ph(1'b0, 1'b0);
    endtask
    // data rises while clock is high
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    // eight data bits then the acknowledge slot, line sampled while clock high
    task automatic byte_io(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, d[i]);
            ph(1'b1, d[i]);
            q[i] = sda_i;
            ph(1'b0, d[i]);
        end
    endtask
    // offset then one data byte; ok is high when every byte was acknowledged
    task automatic write_reg(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
        logic [8:0] q;
        start();
        byte_io({a, 2'b01}, q);
        ok = !q[0];
        byte_io({ofs, 1'b1}, q);
        ok = ok & !q[0];
        byte_io({dat, 1'b1}, q);
        ok = ok & !q[0];
        stop();
    endtask
    // offset write, repeated start, one byte read and ended by a not-acknowledge
    task automatic read_reg(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] dat);
        logic [8:0] q;
        start();
        byte_io({a, 2'b01}, q);
        byte_io({ofs, 1'b1}, q);
        start();
        byte_io({a, 2'b11}, q);
        byte_io(9'h1ff, q);
        dat = q[8:1];
        stop();
    endtask
endmodule
`default_nettype wire

// ===== tb/test_scm_clock_mode_select.sv
// self-checking bench for the clock mode select block
`timescale 1ns/1ps
`default_nettype none
module test_scm_clock_mode_select;
    import scm_pkg::*;
    logic        clock, reset_n, addr_strap, scl, host_oe, dut_oe, sda, ok;
    logic        rate_sel, clk_en, sens_clk, leg, pkt_valid, pkt_pass;
    logic [2:0]  mode_strap;
    logic [6:0]  tgt, dev;
    logic [1:0]  fmt;
    logic [7:0]  cfg, rd;
    logic [5:0]  pkt_dt;
    scm_ref_type ref_src;
    int          failures, n_tests;
    logic [2:0]  codes [4] = '{MODE_SYNC, MODE_EXT, MODE_INTERNAL, MODE_LEGACY};
    scm_ref_type refs  [4] = '{REF_RECOVERED, REF_EXTERNAL, REF_INTERNAL, REF_EXTERNAL};
    // open drain line with pull-up
    assign sda = !(host_oe | dut_oe);
    scm_clock_mode_select u_scm_clock_mode_select (.clock_i(clock), .reset_n_i(reset_n),
        .mode_strap_i(mode_strap), .address_select_strap_i(addr_strap), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(dut_oe), .ref_source_o(ref_src), .internal_rate_select_o(rate_sel),
        .sensor_clock_enable_o(clk_en), .sensor_clock_o(sens_clk), .target_address_o(tgt),
        .legacy_mode_o(leg), .legacy_format_o(fmt), .legacy_port_config_o(cfg),
        .pkt_valid_i(pkt_valid), .pkt_dt_i(pkt_dt), .pkt_pass_o(pkt_pass));
    scm_host_model u_scm_host_model (.clock_i(clock), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // straps stand while reset is held for six cycles
    task automatic do_reset(input logic [2:0] m, input logic a);
        reset_n = 1'b0;
        mode_strap = m;
        addr_strap = a;
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        repeat (2) @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        u_scm_host_model.write_reg(dev, ofs, d, ok);
        check(ok, 1'b1);
    endtask
    task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp);
        u_scm_host_model.read_reg(dev, ofs, rd);
        check(rd, exp);
    endtask
    // one header, verdict stands for the single cycle after it is taken
    task automatic pkt(input logic [5:0] dt, input logic exp);
        pkt_valid = 1'b1;
        pkt_dt = dt;
        @(negedge clock);
        pkt_valid = 1'b0;
        check(pkt_pass, exp);
        @(negedge clock);
    endtask
    // counts sensor clock edges over 240 cycles, one edge of phase slack
    task automatic rate(input logic [7:0] mul, input logic [7:0] divn, input int exp);
        int n;
        logic prev;
        wr(OFS_CLK_MUL, mul);
        wr(OFS_CLK_DIVN, divn);
        n = 0;
        prev = sens_clk;
        repeat (240) begin
            @(negedge clock);
            if (sens_clk !== prev) n++;
            prev = sens_clk;
        end
        check(n >= exp - 1 && n <= exp + 1, 1'b1);
    endtask
    // hang guard
    initial begin
        #400us;
        failures++;
        print_verdict();
    end
    // main sequence
    initial begin
        failures = 0;
        n_tests = 0;
        pkt_valid = 1'b0;
        pkt_dt = 6'h00;
        dev = ADDR_LOW;
        do_reset(MODE_INTERNAL, 1'b0);
        check(ref_src, REF_INTERNAL);
        check(tgt, ADDR_LOW);
        rdchk(OFS_OP_MODE, 8'h03);
        rdchk(OFS_CLK_MUL, 8'h41);
        rate(8'h02, 8'h03, 0);
        wr(OFS_RATE_SEL, 8'h08);
        check(rate_sel, 1'b1);
        wr(OFS_OP_MODE, 8'h05);
        rdchk(OFS_OP_MODE, 8'h03);
        pkt(DT_RAW10, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_OP_MODE, {5'h02, codes[i]});
            check(ref_src, refs[i]);
            check(clk_en, codes[i] != MODE_INTERNAL);
            check(leg, codes[i] == MODE_LEGACY);
        end
        rdchk(OFS_OP_MODE, 8'h15);
        wr(OFS_LEG_FORMAT, 8'h03);
        rdchk(OFS_LEG_FORMAT, 8'h00);
        wr(OFS_LEG_FORMAT, 8'h01);
        check(fmt, FMT_RAW10);
        pkt(DT_RAW10, 1'b1);
        pkt(DT_RAW12, 1'b0);
        wr(OFS_LEG_FORMAT, 8'h02);
        pkt(DT_RAW12, 1'b1);
        wr(OFS_LEG_DT, 8'h45);
        pkt(6'h05, 1'b1);
        wr(OFS_LEG_DT, 8'h05);
        pkt(6'h05, 1'b0);
        wr(OFS_LEG_CFG, 8'h01);
        check(cfg, 8'h01);
        pkt(6'h12, 1'b1);
        wr(OFS_LEG_CFG, 8'h02);
        pkt(6'h1a, 1'b1);
        pkt(6'h12, 1'b0);
        wr(8'h20, 8'h5a);
        rdchk(8'h20, 8'h00);
        wr(OFS_OP_MODE, 8'h10);
        rate(8'h21, 8'h03, 240 * 1 / (2 * 3));
        rate(8'h02, 8'h03, 240 * 2 / 3);
        do_reset(MODE_LEGACY, 1'b1);
        dev = ADDR_HIGH;
        check(tgt, ADDR_HIGH);
        check(leg, 1'b1);
        rdchk(OFS_OP_MODE, 8'h05);
        u_scm_host_model.write_reg(ADDR_LOW, OFS_OP_MODE, 8'h10, ok);
        check(ok, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
